// [hw/mchb_pkg.sv]
// Purpose: Shared constants for the holding register bank of a pressure controller.
// Assumes: Requests arrive already decoded from Modbus frames, one register per request.
// Notes: Register numbers are the one-based numbers used on the bus.
`default_nettype none
package mchb_pkg;
   localparam int unsigned CLOCK_HZ = 200_000_000;
   localparam int unsigned MINUTE_SECONDS = 60;
   localparam longint unsigned MINUTE_CYCLES = longint'(CLOCK_HZ) * longint'(MINUTE_SECONDS);
   localparam int unsigned WORD_W = 16;
   localparam int unsigned INPUT_MEAS_COUNT = 11;
   localparam logic [7:0] FC_READ_HOLD = 8'h03;
   localparam logic [7:0] FC_READ_INPUT = 8'h04;
   localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
   localparam logic [7:0] EXCEPTION_FLAG = 8'h80;
   localparam logic [7:0] EX_NONE = 8'h00;
   localparam logic [7:0] EX_ILLEGAL_FUNCTION = 8'h01;
   localparam logic [7:0] EX_ILLEGAL_ADDRESS = 8'h02;
   localparam logic [7:0] EX_ILLEGAL_VALUE = 8'h03;
   localparam logic [15:0] ADDR_SLAVE = 16'h0001;
   localparam logic [15:0] ADDR_RATE = 16'h0002;
   localparam logic [15:0] ADDR_PARITY = 16'h0003;
   localparam logic [15:0] ADDR_MODEL = 16'h0004;
   localparam logic [15:0] ADDR_HW_REV = 16'h0005;
   localparam logic [15:0] ADDR_FW_REV = 16'h0006;
   localparam logic [15:0] ADDR_RESERVED = 16'h0007;
   localparam logic [15:0] ADDR_TIMEOUT = 16'h0008;
   localparam logic [15:0] ADDR_TERM = 16'h0009;
   localparam logic [15:0] ADDR_RESTORE = 16'h000a;
   localparam logic [15:0] ADDR_ALARM_LOW = 16'h000b;
   localparam logic [15:0] ADDR_ALARM_HIGH = 16'h000c;
   localparam logic [15:0] ADDR_SPAN_LOW = 16'h000d;
   localparam logic [15:0] ADDR_INPUT_FIRST = 16'h0001;
   localparam logic [15:0] ADDR_INPUT_MEAS_LAST = 16'h000b;
   localparam logic [15:0] ADDR_INPUT_LAST = 16'h0014;
   localparam logic [15:0] RST_SLAVE = 16'h0001;
   localparam logic [15:0] RST_RATE = 16'h0002;
   localparam logic [15:0] RST_PARITY = 16'h0001;
   localparam logic [15:0] RST_TIMEOUT = 16'h0000;
   localparam logic [15:0] RST_TERM = 16'h0000;
   localparam logic [15:0] RST_RESTORE = 16'h0000;
   localparam logic [15:0] RST_ALARM_LOW = 16'h0000;
   localparam logic [15:0] RST_SPAN_LOW = 16'h0000;
   localparam logic [15:0] SLAVE_MIN = 16'h0001;
   localparam logic [15:0] SLAVE_MAX = 16'h00f7;
   localparam logic [15:0] RATE_MAX = 16'h0006;
   localparam logic [15:0] PARITY_MAX = 16'h0002;
   localparam logic [15:0] TIMEOUT_MAX = 16'h003c;
   localparam logic [15:0] FLAG_MAX = 16'h0001;
   localparam logic [15:0] RESTORE_GO = 16'h0001;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [15:0] PRESSURE_MARGIN = 16'h0032;
   typedef enum logic [1:0] {
      MCHB_IDLE = 2'b01,
      MCHB_RESTORE = 2'b10
   } mchb_state_t;
endpackage
`default_nettype wire

// [hw/mchb_idle_timer.sv]
// Purpose: Communication loss timer counting whole minutes without bus traffic.
// Assumes: Traffic is a one-cycle pulse per observed request or frame.
// Notes: Expiry clears on the next traffic pulse or when the limit becomes 0.
`default_nettype none
module mchb_idle_timer #(
   parameter longint unsigned MINUTE_CYCLES = mchb_pkg::MINUTE_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic traffic,
   input wire logic [15:0] limit_minutes,
   output logic expired
);
   localparam int PRE_W = $clog2(MINUTE_CYCLES);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MINUTE_CYCLES - 1);
   logic [PRE_W-1:0] prescale;
   logic [15:0] minutes;
   logic minute_tick;
   logic [15:0] next_minutes;
   assign minute_tick = prescale == PRE_LAST;
   assign next_minutes = (minute_tick && minutes < limit_minutes) ? minutes + 16'h0001 : minutes;
   always_ff @(posedge clock) begin
      if (!resetn || traffic) begin
         prescale <= '0;
         minutes <= 16'h0000;
         expired <= 1'b0;
      end else begin
         prescale <= minute_tick ? '0 : prescale + 1'b1;
         minutes <= next_minutes;
         expired <= (limit_minutes != mchb_pkg::ZERO_WORD) && (minutes >= limit_minutes);
      end
   end
   expiry_needs_limit_a: assert property (@(posedge clock) disable iff (!resetn)
      expired |-> $past(limit_minutes) != 16'h0000)
      else $error("Timeout expired with timeout disabled");
   traffic_clears_a: assert property (@(posedge clock) disable iff (!resetn)
      traffic |=> !expired)
      else $error("Traffic did not clear the timeout");
endmodule // mchb_idle_timer
`default_nettype wire

// [hw/mchb_bank.sv]
// Purpose: Holding registers 1 to 13 and input register answers of a pressure controller.
// Assumes: A frame decoder hands over one register request at a time.
// Notes: Setpoint and measured input words come from the control core.
`default_nettype none
module mchb_bank #(
   parameter logic [15:0] FULL_SCALE_PA = 16'h03e8,
   parameter logic [15:0] MIN_RANGE_PA = 16'h0000,
   parameter logic [15:0] MODEL_ID = 16'h0a5a,
   parameter logic [15:0] HW_REVISION = 16'h0103,
   parameter logic [15:0] FW_REVISION = 16'h0407,
   parameter longint unsigned MINUTE_CYCLES = mchb_pkg::MINUTE_CYCLES,
   parameter int unsigned MEAS_COUNT = mchb_pkg::INPUT_MEAS_COUNT
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic req_valid,
   input wire logic [7:0] req_function,
   input wire logic [15:0] req_address,
   input wire logic [15:0] req_wdata,
   input wire logic bus_activity,
   input wire logic [15:0] pressure_setpoint,
   input wire logic [MEAS_COUNT*16-1:0] input_register_words,
   output logic req_ready,
   output logic resp_valid,
   output logic resp_exception,
   output logic [7:0] resp_code,
   output logic [15:0] resp_data,
   output logic [15:0] slave_address,
   output logic [15:0] line_rate_code,
   output logic [15:0] parity_mode,
   output logic [15:0] comm_loss_timeout_minutes,
   output logic [15:0] line_termination_select,
   output logic [15:0] restore_defaults_command,
   output logic [15:0] low_pressure_alarm_limit,
   output logic [15:0] high_pressure_alarm_limit,
   output logic [15:0] low_pressure_span_limit,
   output logic line_termination_resistor,
   output logic force_outputs_zero
);
   mchb_pkg::mchb_state_t state;
   mchb_pkg::mchb_state_t next_state;
   logic take;
   logic is_read_hold;
   logic is_read_input;
   logic is_write;
   logic hold_addr_ok;
   logic input_addr_ok;
   logic ro_addr;
   logic value_ok;
   logic [7:0] ex_code;
   logic wr_commit;
   logic restoring;
   logic restore_start;
   logic signed [16:0] wr_value;
   logic signed [16:0] setpoint_value;
   logic signed [16:0] full_value;
   logic signed [16:0] min_value;
   logic signed [16:0] high_value;
   logic signed [16:0] full_minus_margin;
   logic signed [16:0] min_plus_margin;
   logic low_alarm_ok;
   logic high_alarm_ok;
   logic span_low_ok;
   logic [3:0] meas_index;
   logic [15:0] meas_word;
   logic [15:0] input_rdata;
   logic [15:0] hold_rdata;
   logic [15:0] read_data;
   logic [15:0] next_resp_data;
   logic [7:0] next_resp_code;

   // Request decode
   assign take = req_valid && req_ready;
   assign is_read_hold = req_function == mchb_pkg::FC_READ_HOLD;
   assign is_read_input = req_function == mchb_pkg::FC_READ_INPUT;
   assign is_write = req_function == mchb_pkg::FC_WRITE_SINGLE;
   assign hold_addr_ok = req_address >= mchb_pkg::ADDR_SLAVE
      && req_address <= mchb_pkg::ADDR_SPAN_LOW;
   assign input_addr_ok = req_address >= mchb_pkg::ADDR_INPUT_FIRST
      && req_address <= mchb_pkg::ADDR_INPUT_LAST;
   assign ro_addr = req_address >= mchb_pkg::ADDR_MODEL
      && req_address <= mchb_pkg::ADDR_RESERVED;

   // Pressure ordering checks, signed with a spare bit against overflow
   assign wr_value = {req_wdata[15], req_wdata};
   assign setpoint_value = {pressure_setpoint[15], pressure_setpoint};
   assign full_value = {FULL_SCALE_PA[15], FULL_SCALE_PA};
   assign min_value = {MIN_RANGE_PA[15], MIN_RANGE_PA};
   assign high_value = {high_pressure_alarm_limit[15], high_pressure_alarm_limit};
   assign full_minus_margin = full_value - $signed({1'b0, mchb_pkg::PRESSURE_MARGIN});
   assign min_plus_margin = min_value + $signed({1'b0, mchb_pkg::PRESSURE_MARGIN});
   assign low_alarm_ok = wr_value >= 17'sh00000 && wr_value <= full_minus_margin
      && wr_value <= setpoint_value;
   assign high_alarm_ok = wr_value >= min_plus_margin && wr_value <= full_value
      && wr_value >= setpoint_value;
   assign span_low_ok = wr_value >= min_value && wr_value <= high_value
      && wr_value <= setpoint_value;

   // Value range per writable register
   assign value_ok =
      (req_address == mchb_pkg::ADDR_SLAVE) ?
         (req_wdata >= mchb_pkg::SLAVE_MIN && req_wdata <= mchb_pkg::SLAVE_MAX) :
      (req_address == mchb_pkg::ADDR_RATE) ? (req_wdata <= mchb_pkg::RATE_MAX) :
      (req_address == mchb_pkg::ADDR_PARITY) ? (req_wdata <= mchb_pkg::PARITY_MAX) :
      (req_address == mchb_pkg::ADDR_TIMEOUT) ? (req_wdata <= mchb_pkg::TIMEOUT_MAX) :
      (req_address == mchb_pkg::ADDR_TERM) ? (req_wdata <= mchb_pkg::FLAG_MAX) :
      (req_address == mchb_pkg::ADDR_RESTORE) ? (req_wdata <= mchb_pkg::FLAG_MAX) :
      (req_address == mchb_pkg::ADDR_ALARM_LOW) ? low_alarm_ok :
      (req_address == mchb_pkg::ADDR_ALARM_HIGH) ? high_alarm_ok :
      (req_address == mchb_pkg::ADDR_SPAN_LOW) ? span_low_ok :
      1'b0;

   // Exception selection in Modbus priority order
   assign ex_code =
      !(is_read_hold || is_read_input || is_write) ? mchb_pkg::EX_ILLEGAL_FUNCTION :
      (is_read_hold && !hold_addr_ok) ? mchb_pkg::EX_ILLEGAL_ADDRESS :
      (is_read_input && !input_addr_ok) ? mchb_pkg::EX_ILLEGAL_ADDRESS :
      (is_write && (!hold_addr_ok || ro_addr)) ? mchb_pkg::EX_ILLEGAL_ADDRESS :
      (is_write && !value_ok) ? mchb_pkg::EX_ILLEGAL_VALUE :
      mchb_pkg::EX_NONE;
   assign wr_commit = take && is_write && ex_code == mchb_pkg::EX_NONE;

   // Restore sequencing
   assign restoring = state == mchb_pkg::MCHB_RESTORE;
   assign restore_start = wr_commit && req_address == mchb_pkg::ADDR_RESTORE
      && req_wdata == mchb_pkg::RESTORE_GO;
   assign next_state = restore_start ? mchb_pkg::MCHB_RESTORE : mchb_pkg::MCHB_IDLE;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         state <= mchb_pkg::MCHB_IDLE;
         req_ready <= 1'b1;
      end else begin
         state <= next_state;
         req_ready <= next_state == mchb_pkg::MCHB_IDLE;
      end
   end

   // Holding register storage
   always_ff @(posedge clock) begin
      if (!resetn || restoring) begin
         slave_address <= mchb_pkg::RST_SLAVE;
         line_rate_code <= mchb_pkg::RST_RATE;
         parity_mode <= mchb_pkg::RST_PARITY;
         comm_loss_timeout_minutes <= mchb_pkg::RST_TIMEOUT;
         line_termination_select <= mchb_pkg::RST_TERM;
         restore_defaults_command <= mchb_pkg::RST_RESTORE;
         low_pressure_alarm_limit <= mchb_pkg::RST_ALARM_LOW;
         high_pressure_alarm_limit <= FULL_SCALE_PA;
         low_pressure_span_limit <= mchb_pkg::RST_SPAN_LOW;
      end else if (wr_commit) begin
         unique case (req_address)
            mchb_pkg::ADDR_SLAVE: slave_address <= req_wdata;
            mchb_pkg::ADDR_RATE: line_rate_code <= req_wdata;
            mchb_pkg::ADDR_PARITY: parity_mode <= req_wdata;
            mchb_pkg::ADDR_TIMEOUT: comm_loss_timeout_minutes <= req_wdata;
            mchb_pkg::ADDR_TERM: line_termination_select <= req_wdata;
            mchb_pkg::ADDR_RESTORE: restore_defaults_command <= req_wdata;
            mchb_pkg::ADDR_ALARM_LOW: low_pressure_alarm_limit <= req_wdata;
            mchb_pkg::ADDR_ALARM_HIGH: high_pressure_alarm_limit <= req_wdata;
            default: low_pressure_span_limit <= req_wdata;
         endcase
      end
   end

   // Termination drive follows the stored bit
   always_ff @(posedge clock) begin
      if (!resetn || restoring) begin
         line_termination_resistor <= mchb_pkg::RST_TERM[0];
      end else if (wr_commit && req_address == mchb_pkg::ADDR_TERM) begin
         line_termination_resistor <= req_wdata[0];
      end
   end

   // Read data selection
   assign meas_index = req_address[3:0] - 4'h1;
   assign meas_word = input_register_words[{meas_index, 4'h0} +: 16];
   assign input_rdata = (req_address <= mchb_pkg::ADDR_INPUT_MEAS_LAST) ? meas_word
      : mchb_pkg::ZERO_WORD;
   assign hold_rdata =
      (req_address == mchb_pkg::ADDR_SLAVE) ? slave_address :
      (req_address == mchb_pkg::ADDR_RATE) ? line_rate_code :
      (req_address == mchb_pkg::ADDR_PARITY) ? parity_mode :
      (req_address == mchb_pkg::ADDR_MODEL) ? MODEL_ID :
      (req_address == mchb_pkg::ADDR_HW_REV) ? HW_REVISION :
      (req_address == mchb_pkg::ADDR_FW_REV) ? FW_REVISION :
      (req_address == mchb_pkg::ADDR_TIMEOUT) ? comm_loss_timeout_minutes :
      (req_address == mchb_pkg::ADDR_TERM) ? line_termination_select :
      (req_address == mchb_pkg::ADDR_RESTORE) ? restore_defaults_command :
      (req_address == mchb_pkg::ADDR_ALARM_LOW) ? low_pressure_alarm_limit :
      (req_address == mchb_pkg::ADDR_ALARM_HIGH) ? high_pressure_alarm_limit :
      (req_address == mchb_pkg::ADDR_SPAN_LOW) ? low_pressure_span_limit :
      mchb_pkg::ZERO_WORD;
   assign read_data = is_read_input ? input_rdata : is_read_hold ? hold_rdata : req_wdata;
   assign next_resp_data = (ex_code != mchb_pkg::EX_NONE) ? {8'h00, ex_code} : read_data;
   assign next_resp_code = (ex_code != mchb_pkg::EX_NONE)
      ? (req_function | mchb_pkg::EXCEPTION_FLAG) : req_function;

   // Response stage
   always_ff @(posedge clock) begin
      if (!resetn) begin
         resp_valid <= 1'b0;
         resp_exception <= 1'b0;
         resp_code <= 8'h00;
         resp_data <= 16'h0000;
      end else begin
         resp_valid <= take;
         if (take) begin
            resp_exception <= ex_code != mchb_pkg::EX_NONE;
            resp_code <= next_resp_code;
            resp_data <= next_resp_data;
         end
      end
   end

   // Communication loss timer
   mchb_idle_timer #(
      .MINUTE_CYCLES(MINUTE_CYCLES)
   ) u_idle_timer (
      .clock(clock),
      .resetn(resetn),
      .traffic(bus_activity || take),
      .limit_minutes(comm_loss_timeout_minutes),
      .expired(force_outputs_zero)
   );

   input_read_a: assert property (@(posedge clock) disable iff (!resetn)
      take && is_read_input && req_address > mchb_pkg::ADDR_INPUT_MEAS_LAST
      && req_address <= mchb_pkg::ADDR_INPUT_LAST
      |=> resp_valid && !resp_exception && resp_data == 16'h0000)
      else $error("Reserved input register did not read zero");
   rate_bound_a: assert property (@(posedge clock) disable iff (!resetn)
      take && is_write && req_address == mchb_pkg::ADDR_RATE && req_wdata > mchb_pkg::RATE_MAX
      |=> resp_exception && resp_data == 16'h0003 && $stable(line_rate_code))
      else $error("Line rate code above 6 accepted");
   model_read_a: assert property (@(posedge clock) disable iff (!resetn)
      take && is_read_hold && req_address == mchb_pkg::ADDR_MODEL
      |=> resp_valid && !resp_exception && resp_data == MODEL_ID)
      else $error("Model identifier read wrong");
   model_write_a: assert property (@(posedge clock) disable iff (!resetn)
      take && is_write && req_address == mchb_pkg::ADDR_MODEL
      |=> resp_exception && resp_data == 16'h0002)
      else $error("Write to model identifier not refused");
   hw_read_a: assert property (@(posedge clock) disable iff (!resetn)
      take && is_read_hold && req_address == mchb_pkg::ADDR_HW_REV |=> resp_data == HW_REVISION)
      else $error("Hardware revision read wrong");
   fw_read_a: assert property (@(posedge clock) disable iff (!resetn)
      take && is_read_hold && req_address == mchb_pkg::ADDR_FW_REV |=> resp_data == FW_REVISION)
      else $error("Firmware revision read wrong");
   term_drive_a: assert property (@(posedge clock) disable iff (!resetn)
      take && is_write && req_address == mchb_pkg::ADDR_TERM && req_wdata == 16'h0001
      && !restoring |=> line_termination_resistor)
      else $error("Termination not connected after writing 1");
   restore_clear_a: assert property (@(posedge clock) disable iff (!resetn)
      restore_start |=> restoring ##1 (restore_defaults_command == 16'h0000
      && high_pressure_alarm_limit == FULL_SCALE_PA && line_rate_code == 16'h0002 && req_ready))
      else $error("Restore did not reload defaults and clear itself");
   low_alarm_order_a: assert property (@(posedge clock) disable iff (!resetn)
      take && is_write && req_address == mchb_pkg::ADDR_ALARM_LOW && wr_value > setpoint_value
      |=> resp_exception && $stable(low_pressure_alarm_limit))
      else $error("Low alarm above setpoint accepted");
   high_alarm_order_a: assert property (@(posedge clock) disable iff (!resetn)
      take && is_write && req_address == mchb_pkg::ADDR_ALARM_HIGH && wr_value < setpoint_value
      |=> resp_exception && $stable(high_pressure_alarm_limit))
      else $error("High alarm below setpoint accepted");
   span_order_a: assert property (@(posedge clock) disable iff (!resetn)
      take && is_write && req_address == mchb_pkg::ADDR_SPAN_LOW
      && (wr_value > setpoint_value || wr_value > high_value)
      |=> resp_exception && $stable(low_pressure_span_limit))
      else $error("Low span limit out of order accepted");
   value_reject_a: assert property (@(posedge clock) disable iff (!resetn)
      take && ex_code == mchb_pkg::EX_ILLEGAL_VALUE
      |=> resp_code == ($past(req_function) | 8'h80) && resp_data == 16'h0003)
      else $error("Illegal value exception malformed");
endmodule // mchb_bank
`default_nettype wire

// [sim/mchb_master.sv]
// Purpose: Modbus master stand-in driving the decoded request port of the bank.
// Assumes: One register per request; answer registered on the taking edge.
// Notes: Released request lines show the inverse of their last value.
`default_nettype none
module mchb_master (
   input wire logic clock,
   output logic req_valid,
   output logic [7:0] req_function,
   output logic [15:0] req_address,
   output logic [15:0] req_wdata,
   input wire logic req_ready,
   input wire logic resp_valid,
   input wire logic resp_exception,
   input wire logic [7:0] resp_code,
   input wire logic [15:0] resp_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic got_valid, got_exc, got_ready;
   logic [7:0] got_code;
   logic [15:0] got_data;
   initial begin
      req_valid = 1'b0;
      req_function = 8'h00;
      req_address = 16'h0000;
      req_wdata = 16'h0000;
   end
   // Input words are fetched only with the read-input function code
   task automatic xfer(input logic [7:0] fn, input logic [15:0] addr, input logic [15:0] wd);
      int n;
      @(posedge clock);
      req_valid <= 1'b1;
      req_function <= fn;
      req_address <= addr;
      req_wdata <= wd;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (req_ready !== 1'b1 && n < 50);
      req_valid <= 1'b0;
      req_function <= ~fn;
      req_address <= ~addr;
      req_wdata <= ~wd;
      // Answer is read mid-cycle, once it has settled
      @(negedge clock);
      got_valid = resp_valid;
      got_exc = resp_exception;
      got_code = resp_code;
      got_data = resp_data;
      got_ready = req_ready;
   endtask
endmodule // mchb_master
`default_nettype wire

// [sim/mchb_bank_tb.sv]
// Purpose: Self-checking bench for the holding register bank.
// Assumes: A minute is shortened to 20 clock cycles.
// Notes: Expected values come from the factory table and value ranges.
`default_nettype none
module mchb_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] MID = 16'h0c3d; // Arbitrary identity value
   localparam logic [15:0] HWR = 16'h0214; // Arbitrary identity value
   localparam logic [15:0] FWR = 16'h0309; // Arbitrary identity value
   logic clock, resetn, bus_activity;
   logic [15:0] pressure_setpoint;
   logic [175:0] words;
   logic req_valid, req_ready, resp_valid, resp_exception, term_res, force_zero;
   logic [7:0] req_function, resp_code;
   logic [15:0] req_address, req_wdata, resp_data, timeout_q, restore_q, alarm_low_q;
   logic [15:0] slave_q, rate_q, parity_q, term_sel_q, alarm_high_q, span_q;
   logic [15:0] rv [1:13];
   int error_cnt = 0;
   int compares = 0;
   int cycles = 0;
   mchb_bank #(.MODEL_ID(MID), .HW_REVISION(HWR), .FW_REVISION(FWR), .MINUTE_CYCLES(20))
   i_mchb_bank (.clock(clock), .resetn(resetn), .req_valid(req_valid),
      .req_function(req_function), .req_address(req_address), .req_wdata(req_wdata),
      .bus_activity(bus_activity), .pressure_setpoint(pressure_setpoint),
      .input_register_words(words), .req_ready(req_ready), .resp_valid(resp_valid),
      .resp_exception(resp_exception), .resp_code(resp_code), .resp_data(resp_data),
      .slave_address(slave_q), .line_rate_code(rate_q), .parity_mode(parity_q),
      .comm_loss_timeout_minutes(timeout_q), .line_termination_select(term_sel_q),
      .restore_defaults_command(restore_q), .low_pressure_alarm_limit(alarm_low_q),
      .high_pressure_alarm_limit(alarm_high_q), .low_pressure_span_limit(span_q),
      .line_termination_resistor(term_res), .force_outputs_zero(force_zero));
   mchb_master i_mchb_master (.clock(clock), .req_valid(req_valid),
      .req_function(req_function), .req_address(req_address), .req_wdata(req_wdata),
      .req_ready(req_ready), .resp_valid(resp_valid), .resp_exception(resp_exception),
      .resp_code(resp_code), .resp_data(resp_data));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic op(input logic [7:0] fn, input logic [15:0] a, input logic [15:0] wd,
         input logic [15:0] exp, input logic ex);
      i_mchb_master.xfer(fn, a, wd);
      chk("resp_valid", {15'h0000, i_mchb_master.got_valid}, 16'h0001);
      chk("resp_exception", {15'h0000, i_mchb_master.got_exc}, {15'h0000, ex});
      chk("resp_code", {8'h00, i_mchb_master.got_code}, {8'h00, ex ? fn | 8'h80 : fn});
      chk("resp_data", i_mchb_master.got_data, exp);
   endtask
   task automatic end_of_test;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      resetn = 1'b0;
      bus_activity = 1'b0;
      pressure_setpoint = 16'h01f4;
      for (int n = 0; n < 11; n++) words[n*16 +: 16] = 16'h1000 + 16'(n);
      rv = '{16'h0001, 16'h0002, 16'h0001, MID, HWR, FWR, 16'h0000, 16'h0000, 16'h0000,
         16'h0000, 16'h0000, 16'h03e8, 16'h0000};
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      for (int a = 1; a <= 13; a++) op(8'h03, 16'(a), 16'h0000, rv[a], 1'b0);
      op(8'h04, 16'h0001, 16'h0000, 16'h1000, 1'b0);
      op(8'h04, 16'h000b, 16'h0000, 16'h100a, 1'b0);
      op(8'h04, 16'h0014, 16'h0000, 16'h0000, 1'b0);
      op(8'h04, 16'h0015, 16'h0000, 16'h0002, 1'b1);
      for (int k = 0; k <= 6; k++) op(8'h06, 16'h0002, 16'(k), 16'(k), 1'b0);
      op(8'h06, 16'h0002, 16'h0007, 16'h0003, 1'b1);
      op(8'h03, 16'h0002, 16'h0000, 16'h0006, 1'b0);
      chk("rate_reg", rate_q, 16'h0006);
      op(8'h06, 16'h0004, 16'h0001, 16'h0002, 1'b1);
      op(8'h03, 16'h0004, 16'h0000, MID, 1'b0);
      op(8'h06, 16'h0007, 16'h0001, 16'h0002, 1'b1);
      op(8'h10, 16'h0001, 16'h0000, 16'h0001, 1'b1);
      op(8'h03, 16'h000e, 16'h0000, 16'h0002, 1'b1);
      op(8'h06, 16'h0001, 16'h00f8, 16'h0003, 1'b1);
      op(8'h06, 16'h0001, 16'h00f7, 16'h00f7, 1'b0);
      op(8'h06, 16'h0003, 16'h0003, 16'h0003, 1'b1);
      op(8'h06, 16'h0003, 16'h0002, 16'h0002, 1'b0);
      op(8'h06, 16'h000a, 16'h0000, 16'h0000, 1'b0);
      chk("slave_reg", slave_q, 16'h00f7);
      chk("parity_reg", parity_q, 16'h0002);
      op(8'h06, 16'h0009, 16'h0001, 16'h0001, 1'b0);
      chk("termination", {15'h0000, term_res}, 16'h0001);
      chk("term_reg", term_sel_q, 16'h0001);
      op(8'h06, 16'h0009, 16'h0000, 16'h0000, 1'b0);
      chk("termination", {15'h0000, term_res}, 16'h0000);
      op(8'h06, 16'h000b, 16'h01f5, 16'h0003, 1'b1);
      op(8'h06, 16'h000b, 16'h01f4, 16'h01f4, 1'b0);
      chk("alarm_low", alarm_low_q, 16'h01f4);
      op(8'h06, 16'h000c, 16'h01f3, 16'h0003, 1'b1);
      op(8'h06, 16'h000c, 16'h01f4, 16'h01f4, 1'b0);
      op(8'h06, 16'h000d, 16'h01f5, 16'h0003, 1'b1);
      op(8'h06, 16'h000d, 16'h0190, 16'h0190, 1'b0);
      chk("span_low", span_q, 16'h0190);
      chk("alarm_high", alarm_high_q, 16'h01f4);
      @(posedge clock);
      pressure_setpoint <= 16'h03e8;
      op(8'h06, 16'h000b, 16'h03b7, 16'h0003, 1'b1);
      op(8'h06, 16'h000b, 16'h03b6, 16'h03b6, 1'b0);
      op(8'h06, 16'h000d, 16'h01f5, 16'h0003, 1'b1);
      op(8'h06, 16'h000a, 16'h0001, 16'h0001, 1'b0);
      chk("req_ready", {15'h0000, i_mchb_master.got_ready}, 16'h0000);
      chk("restore_reg", restore_q, 16'h0001);
      for (int a = 1; a <= 13; a++) op(8'h03, 16'(a), 16'h0000, rv[a], 1'b0);
      chk("slave_reg", slave_q, 16'h0001);
      chk("rate_reg", rate_q, 16'h0002);
      chk("parity_reg", parity_q, 16'h0001);
      chk("term_reg", term_sel_q, 16'h0000);
      chk("alarm_high", alarm_high_q, 16'h03e8);
      chk("span_low", span_q, 16'h0000);
      op(8'h06, 16'h0008, 16'h003d, 16'h0003, 1'b1);
      op(8'h06, 16'h0008, 16'h0001, 16'h0001, 1'b0);
      chk("timeout_reg", timeout_q, 16'h0001);
      repeat (10) @(posedge clock);
      chk("force_zero", {15'h0000, force_zero}, 16'h0000);
      repeat (20) @(posedge clock);
      chk("force_zero", {15'h0000, force_zero}, 16'h0001);
      bus_activity <= 1'b1;
      @(posedge clock);
      bus_activity <= 1'b0;
      repeat (2) @(posedge clock);
      chk("force_zero", {15'h0000, force_zero}, 16'h0000);
      end_of_test();
   end
endmodule // mchb_bank_tb
`default_nettype wire
